//--- core/cis_event_cells.sv
/*
 * Status cells: live condition, or a held rising edge until a write-one clear.
 * Assumes synchronised conditions and one-cycle clear pulses.
 */
module cis_event_cells #(
    parameter int W = 11
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] latch_sel,
    input  wire logic [W-1:0] clear,
    output logic      [W-1:0] status,
    output logic      [W-1:0] latched
);

    // All state of the cells: previous condition and held latch bits.
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] held;
    } cis_cell_state_type;

    cis_cell_state_type state_q;    // Registered state.
    cis_cell_state_type state_d;    // Next state.

    // Edge detection and latching; a rising edge in the clearing cycle wins.
    always_comb begin
        state_d      = state_q;
        state_d.prev = cond;
        for (int i = 0; i < W; i++) begin
            // Only rising edges set a held bit.
            if (latch_sel[i]) begin
                state_d.held[i] = (cond[i] & ~state_q.prev[i])
                                | (state_q.held[i] & ~clear[i]);
            end else begin
                // Live mode keeps no stale latch behind.
                state_d.held[i] = 1'b0;
            end
        end
    end

    // Register the cell state.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Each bit reads either its live condition or its held latch.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            status[i] = latch_sel[i] ? state_q.held[i] : cond[i];
        end
        latched = state_q.held;
    end

endmodule

//--- core/cis_pkg.sv
/*
 * Constants and carrier types of the interrupt status block.
 * Assumes a 32-bit APB master; users never import this package.
 */
package cis_pkg;

    // Bus and register widths and the number of lanes.
    localparam int CIS_ADDR_W = 14;
    localparam int CIS_DATA_W = 32;
    localparam int CIS_REG_W  = 8;
    localparam int CIS_NLANES = 8;

    // Register indices; the byte address of each is four times its index.
    localparam logic [11:0] CIS_IDX_MODE_CHB   = 12'h022;
    localparam logic [11:0] CIS_IDX_STATUS_PRI = 12'h023;
    localparam logic [11:0] CIS_IDX_STATUS_SEC = 12'h024;
    localparam logic [11:0] CIS_IDX_MODE_PRI   = 12'h040;
    localparam logic [11:0] CIS_IDX_STATUS_CHB = 12'h041;
    localparam logic [11:0] CIS_IDX_MASK_PRI   = 12'h042;
    localparam logic [11:0] CIS_IDX_MASK_CHB   = 12'h043;
    localparam logic [11:0] CIS_IDX_LINK_CTRL  = 12'h044;
    localparam logic [11:0] CIS_IDX_LANE_FULL  = 12'h30c;
    localparam logic [11:0] CIS_IDX_LANE_EMPTY = 12'h30d;

    // Bit positions inside the primary status and mode registers.
    localparam int CIS_BIT_CAL_PASS  = 7;
    localparam int CIS_BIT_CAL_FAIL  = 6;
    localparam int CIS_BIT_CONV_LOST = 5;
    localparam int CIS_BIT_CONV_LOCK = 4;
    localparam int CIS_BIT_LINK_LOST = 3;
    localparam int CIS_BIT_LINK_LOCK = 2;
    localparam int CIS_BIT_LANE_ERR  = 1;

    // Bit positions inside the channel B status and mode registers.
    localparam int CIS_BIT_CHB_ROTATE = 2;
    localparam int CIS_BIT_CHB_WINDOW = 1;
    localparam int CIS_BIT_CHB_TRIP   = 0;

    // Bit position of the link enable inside the link control register.
    localparam int CIS_BIT_LINK_EN = 0;

    // Event vector: primary bits sit at [7:0], channel B bits at [10:8].
    localparam int CIS_EV_W     = 11;
    localparam int CIS_CHB_BASE = 8;

    // Implemented bits; all others are reserved and read as zero.
    localparam logic [7:0] CIS_PRI_IMPL = 8'hfe;
    localparam logic [7:0] CIS_CHB_IMPL = 8'h07;

    // Values after reset.
    localparam logic [7:0] CIS_MODE_RST   = 8'h00;
    localparam logic [7:0] CIS_MASK_RST   = 8'hff;
    localparam logic [7:0] CIS_CTRL_RST   = 8'h00;
    localparam logic [7:0] CIS_STATUS_RST = 8'h00;

    // APB request from the master.
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [CIS_ADDR_W-1:0] paddr;
        logic [CIS_DATA_W-1:0] pwdata;
    } cis_apb_req_type;

    // APB answer to the master.
    typedef struct packed {
        logic [CIS_DATA_W-1:0] prdata;
        logic                  pready;
        logic                  pslverr;
    } cis_apb_rsp_type;

    // Raw monitored conditions, all active high, from other clock domains.
    typedef struct packed {
        logic cal_passed;
        logic cal_failed;
        logic conv_loop_lock_lost;
        logic conv_loop_locked;
        logic link_loop_lock_lost;
        logic link_loop_locked;
        logic chan_b_align_rotate;
        logic chan_b_outside_window;
        logic chan_b_align_tripped;
    } cis_cond_type;

endpackage

//--- core/cis_top.sv
/*
 * Interrupt status controller: APB mode, mask and link registers,
 * live or latched status bits and an active-low interrupt line.
 * Assumes condition and lane FIFO inputs asynchronous to ref_clk.
 */
// The APB slave port was decided locally.
module cis_top #(
    parameter int NLANES = cis_pkg::CIS_NLANES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire cis_pkg::cis_apb_req_type apb_req,
    output cis_pkg::cis_apb_rsp_type  apb_rsp,
    input  wire cis_pkg::cis_cond_type cond_in,
    input  wire logic [NLANES-1:0]    lane_fifo_full,
    input  wire logic [NLANES-1:0]    lane_fifo_empty,
    output logic                      link_enable,
    output logic                      irq_n
);

    // All state of the controller.
    typedef struct packed {
        cis_pkg::cis_cond_type cond_s1;      // First synchroniser stage.
        cis_pkg::cis_cond_type cond_s2;      // Second synchroniser stage.
        logic [NLANES-1:0]     full_s1;      // Lane full, first stage.
        logic [NLANES-1:0]     full_s2;      // Lane full, second stage.
        logic [NLANES-1:0]     empty_s1;     // Lane empty, first stage.
        logic [NLANES-1:0]     empty_s2;     // Lane empty, second stage.
        logic [7:0]            mode_pri;     // Latch selects, primary layout.
        logic [7:0]            mode_chb;     // Latch selects, channel B layout.
        logic [7:0]            mask_pri;     // Interrupt mask, primary layout.
        logic [7:0]            mask_chb;     // Interrupt mask, channel B layout.
        logic [7:0]            link_ctrl;    // Link control register.
        logic                  lane_err;     // Sticky lane buffer error.
        logic                  irq_n;        // Registered interrupt line.
        logic [31:0]           prdata;       // Read data for the access phase.
        logic                  pslverr;      // Error answer for the access phase.
    } cis_state_type;

    cis_state_type                 state_q;      // Registered state.
    cis_state_type                 state_d;      // Next state.
    logic [cis_pkg::CIS_EV_W-1:0]  ev_cond;      // Conditions into the cells.
    logic [cis_pkg::CIS_EV_W-1:0]  ev_sel;       // Latch selects into the cells.
    logic [cis_pkg::CIS_EV_W-1:0]  ev_clear;     // Write-one clear pulses.
    logic [cis_pkg::CIS_EV_W-1:0]  ev_status;    // Readable status bits.
    logic [cis_pkg::CIS_EV_W-1:0]  ev_latched;   // Held latch bits.
    logic [11:0]                   reg_idx;      // Word index of the access.
    logic                          wr_access;    // Write completing this cycle.
    logic                          setup;        // Setup phase of any access.

    // Tells whether a word index names a register of this block.
    function automatic logic cis_mapped(input logic [11:0] idx);
        case (idx)
            cis_pkg::CIS_IDX_MODE_CHB,
            cis_pkg::CIS_IDX_STATUS_PRI,
            cis_pkg::CIS_IDX_STATUS_SEC,
            cis_pkg::CIS_IDX_MODE_PRI,
            cis_pkg::CIS_IDX_STATUS_CHB,
            cis_pkg::CIS_IDX_MASK_PRI,
            cis_pkg::CIS_IDX_MASK_CHB,
            cis_pkg::CIS_IDX_LINK_CTRL,
            cis_pkg::CIS_IDX_LANE_FULL,
            cis_pkg::CIS_IDX_LANE_EMPTY: cis_mapped = 1'b1;
            default:                     cis_mapped = 1'b0;
        endcase
    endfunction

    // Widens a lane vector into a bus word with zeros above.
    function automatic logic [31:0] cis_lane_word(input logic [NLANES-1:0] v);
        cis_lane_word = '0;
        for (int i = 0; i < NLANES; i++) begin
            cis_lane_word[i] = v[i];
        end
    endfunction

    // Bus decode: word index from the byte address, misaligned never matches.
    always_comb begin
        reg_idx   = apb_req.paddr[13:2];
        setup     = apb_req.psel & ~apb_req.penable;
        wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & (apb_req.paddr[1:0] == 2'b00) & cis_mapped(reg_idx);
    end

    // Gather conditions and selects into the event vector; bit 0 is reserved.
    always_comb begin
        ev_cond  = '0;
        ev_sel   = '0;
        ev_cond[cis_pkg::CIS_BIT_CAL_PASS]  = state_q.cond_s2.cal_passed;
        ev_cond[cis_pkg::CIS_BIT_CAL_FAIL]  = state_q.cond_s2.cal_failed;
        ev_cond[cis_pkg::CIS_BIT_CONV_LOST] = state_q.cond_s2.conv_loop_lock_lost;
        ev_cond[cis_pkg::CIS_BIT_CONV_LOCK] = state_q.cond_s2.conv_loop_locked;
        ev_cond[cis_pkg::CIS_BIT_LINK_LOST] = state_q.cond_s2.link_loop_lock_lost;
        ev_cond[cis_pkg::CIS_BIT_LINK_LOCK] = state_q.cond_s2.link_loop_locked;
        ev_cond[cis_pkg::CIS_BIT_LANE_ERR]  = state_q.lane_err;
        ev_cond[cis_pkg::CIS_CHB_BASE + cis_pkg::CIS_BIT_CHB_ROTATE] =
            state_q.cond_s2.chan_b_align_rotate;
        ev_cond[cis_pkg::CIS_CHB_BASE + cis_pkg::CIS_BIT_CHB_WINDOW] =
            state_q.cond_s2.chan_b_outside_window;
        ev_cond[cis_pkg::CIS_CHB_BASE + cis_pkg::CIS_BIT_CHB_TRIP] =
            state_q.cond_s2.chan_b_align_tripped;
        // Reserved positions keep a zero select so they stay zero.
        ev_sel[7:0]  = state_q.mode_pri & cis_pkg::CIS_PRI_IMPL;
        ev_sel[10:8] = state_q.mode_chb[2:0];
    end

    // Write-one clears reach only latched bits of implemented positions.
    always_comb begin
        ev_clear = '0;
        if (wr_access && reg_idx == cis_pkg::CIS_IDX_STATUS_PRI) begin
            ev_clear[7:0] = apb_req.pwdata[7:0] & cis_pkg::CIS_PRI_IMPL;
        end
        if (wr_access && reg_idx == cis_pkg::CIS_IDX_STATUS_CHB) begin
            ev_clear[10:8] = apb_req.pwdata[2:0];
        end
    end

    // Status cells: live or rising-edge latched per select.
    cis_event_cells #(
        .W (cis_pkg::CIS_EV_W)
    ) u_cells (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .cond      (ev_cond),
        .latch_sel (ev_sel),
        .clear     (ev_clear),
        .status    (ev_status),
        .latched   (ev_latched)
    );

    // Next-state logic: synchronisers, lane error, registers and read data.
    always_comb begin
        state_d = state_q;

        // Two-stage synchronisers; the first stage feeds only the second.
        state_d.cond_s1  = cond_in;
        state_d.cond_s2  = state_q.cond_s1;
        state_d.full_s1  = lane_fifo_full;
        state_d.full_s2  = state_q.full_s1;
        state_d.empty_s1 = lane_fifo_empty;
        state_d.empty_s2 = state_q.empty_s1;

        // Lane error sets on any full or empty lane and holds while the link runs.
        if (!state_q.link_ctrl[cis_pkg::CIS_BIT_LINK_EN]) begin
            state_d.lane_err = 1'b0;
        end else if ((|state_q.full_s2) || (|state_q.empty_s2)) begin
            state_d.lane_err = 1'b1;
        end

        // Register writes take effect at the edge that ends the access phase.
        if (wr_access) begin
            case (reg_idx)
                cis_pkg::CIS_IDX_MODE_PRI: begin
                    state_d.mode_pri = apb_req.pwdata[7:0] & cis_pkg::CIS_PRI_IMPL;
                end
                cis_pkg::CIS_IDX_MODE_CHB: begin
                    state_d.mode_chb = apb_req.pwdata[7:0] & cis_pkg::CIS_CHB_IMPL;
                end
                cis_pkg::CIS_IDX_MASK_PRI: begin
                    state_d.mask_pri = apb_req.pwdata[7:0] & cis_pkg::CIS_PRI_IMPL;
                end
                cis_pkg::CIS_IDX_MASK_CHB: begin
                    state_d.mask_chb = apb_req.pwdata[7:0] & cis_pkg::CIS_CHB_IMPL;
                end
                cis_pkg::CIS_IDX_LINK_CTRL: begin
                    state_d.link_ctrl = {7'h00, apb_req.pwdata[cis_pkg::CIS_BIT_LINK_EN]};
                end
                default: begin
                    // Status and lane registers hold no writable bits.
                    state_d.link_ctrl = state_q.link_ctrl;
                end
            endcase
        end

        // Interrupt line low while any unmasked bit is held latched.
        state_d.irq_n = ~(|(ev_latched & {state_q.mask_chb[2:0], state_q.mask_pri}));

        // Read data is captured in the setup phase and stands through the access.
        if (setup) begin
            state_d.prdata  = '0;
            state_d.pslverr = ~cis_mapped(reg_idx) | (apb_req.paddr[1:0] != 2'b00);
            if (!apb_req.pwrite) begin
                case (reg_idx)
                    cis_pkg::CIS_IDX_STATUS_PRI: begin
                        state_d.prdata[7:0] = ev_status[7:0] & cis_pkg::CIS_PRI_IMPL;
                    end
                    cis_pkg::CIS_IDX_STATUS_CHB: begin
                        state_d.prdata[2:0] = ev_status[10:8];
                    end
                    cis_pkg::CIS_IDX_MODE_PRI: begin
                        state_d.prdata[7:0] = state_q.mode_pri;
                    end
                    cis_pkg::CIS_IDX_MODE_CHB: begin
                        state_d.prdata[7:0] = state_q.mode_chb;
                    end
                    cis_pkg::CIS_IDX_MASK_PRI: begin
                        state_d.prdata[7:0] = state_q.mask_pri;
                    end
                    cis_pkg::CIS_IDX_MASK_CHB: begin
                        state_d.prdata[7:0] = state_q.mask_chb;
                    end
                    cis_pkg::CIS_IDX_LINK_CTRL: begin
                        state_d.prdata[7:0] = state_q.link_ctrl;
                    end
                    cis_pkg::CIS_IDX_LANE_FULL: begin
                        state_d.prdata = cis_lane_word(state_q.full_s2);
                    end
                    cis_pkg::CIS_IDX_LANE_EMPTY: begin
                        state_d.prdata = cis_lane_word(state_q.empty_s2);
                    end
                    default: begin
                        // The secondary status word and unmapped words read zero.
                        state_d.prdata = '0;
                    end
                endcase
            end
        end
    end

    // Register the whole controller state.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q           <= '0;
            state_q.mode_pri  <= cis_pkg::CIS_MODE_RST;
            state_q.mode_chb  <= cis_pkg::CIS_MODE_RST;
            state_q.mask_pri  <= cis_pkg::CIS_MASK_RST & cis_pkg::CIS_PRI_IMPL;
            state_q.mask_chb  <= cis_pkg::CIS_MASK_RST & cis_pkg::CIS_CHB_IMPL;
            state_q.link_ctrl <= cis_pkg::CIS_CTRL_RST;
            state_q.irq_n     <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs: zero-wait APB answer, data and lines from flip-flops.
    always_comb begin
        apb_rsp.prdata  = state_q.prdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = state_q.pslverr & apb_req.psel & apb_req.penable;
        link_enable     = state_q.link_ctrl[cis_pkg::CIS_BIT_LINK_EN];
        irq_n           = state_q.irq_n;
    end

endmodule

//--- verif/cis_cond_source.sv
/*
 * Converter side model: drives condition and lane pins as commanded.
 * Assumes commands change just after a rising edge.
 */
module cis_cond_source #(
    parameter int NLANES = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire cis_pkg::cis_cond_type cond_cmd,
    input  wire logic [NLANES-1:0]     full_cmd,
    input  wire logic [NLANES-1:0]     empty_cmd,
    output cis_pkg::cis_cond_type      cond_in,
    output logic      [NLANES-1:0]     lane_fifo_full,
    output logic      [NLANES-1:0]     lane_fifo_empty
);
    // Pins follow the command one edge later.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cond_in <= '0;
            lane_fifo_full <= '0;
            lane_fifo_empty <= '0;
        end else begin
            cond_in <= cond_cmd;
            lane_fifo_full <= full_cmd;
            lane_fifo_empty <= empty_cmd;
        end
    end
endmodule

//--- verif/cis_top_sva.sv
/*
 * Port checker of the interrupt status block.
 * Assumes one ref_clk domain with reset rst.
 */
module cis_top_sva #(
    parameter int NLANES = 8
) (
    input wire logic                     ref_clk,
    input wire logic                     rst,
    input wire cis_pkg::cis_apb_req_type apb_req,
    input wire cis_pkg::cis_apb_rsp_type apb_rsp,
    input wire cis_pkg::cis_cond_type    cond_in,
    input wire logic [NLANES-1:0]        lane_fifo_full,
    input wire logic [NLANES-1:0]        lane_fifo_empty,
    input wire logic                     link_enable,
    input wire logic                     irq_n
);
    logic [11:0] idx;        // Word index of the request.
    logic        acc;        // Aligned access phase.
    logic        rd_acc;     // Aligned read access phase.
    logic        wr_acc;     // Aligned write access phase.
    logic        mode_any;   // Some latch select is set.
    logic [7:0]  mode_pri_q; // Shadow of the primary mode register.
    logic [2:0]  mode_chb_q; // Shadow of the channel B mode register.
    logic [8:0]  cond_q;     // Condition pins one edge ago.
    logic [2:0]  stab_q;     // Edges without pin change or write, saturating.

    assign idx = apb_req.paddr[13:2];
    assign acc = apb_req.psel && apb_req.penable && (apb_req.paddr[1:0] == 2'h0);
    assign rd_acc = acc && !apb_req.pwrite;
    assign wr_acc = acc && apb_req.pwrite;
    assign mode_any = (mode_pri_q != 8'h00) || (mode_chb_q != 3'h0);

    // Mirror mode writes and count how long the inputs have been steady.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_pri_q <= 8'h00;
            mode_chb_q <= 3'h0;
            cond_q <= 9'h000;
            stab_q <= 3'h0;
        end else begin
            cond_q <= cond_in;
            if (wr_acc && idx == cis_pkg::CIS_IDX_MODE_PRI) begin
                mode_pri_q <= apb_req.pwdata[7:0] & 8'hfe;
            end
            if (wr_acc && idx == cis_pkg::CIS_IDX_MODE_CHB) begin
                mode_chb_q <= apb_req.pwdata[2:0];
            end
            if (cond_in != cond_q || wr_acc) begin
                stab_q <= 3'h0;
            end else if (stab_q != 3'h7) begin
                stab_q <= stab_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // A read of one status register after the pins have settled.
    sequence s_live_read(logic [11:0] ix);
        rd_acc && idx == ix && stab_q >= 3'h5;
    endsequence

    // Every latch select clear for three edges running.
    sequence s_all_live;
        !mode_any [*3];
    endsequence

    a_chb_live_read: assert property ((s_live_read(cis_pkg::CIS_IDX_STATUS_CHB) ##0
        mode_chb_q == 3'h0) |-> apb_rsp.prdata[2:0] == cond_in[2:0])
        else $error("channel b live status wrong");
    a_pri_live_read: assert property ((s_live_read(cis_pkg::CIS_IDX_STATUS_PRI) ##0
        mode_pri_q[7:2] == 6'h00) |-> apb_rsp.prdata[7:2] == cond_in[8:3])
        else $error("primary live status wrong");
    a_reserved_read: assert property (
        rd_acc && idx == cis_pkg::CIS_IDX_STATUS_SEC |-> apb_rsp.prdata == 32'h0)
        else $error("secondary status not zero");
    a_pri_spare_zero: assert property (rd_acc && idx == cis_pkg::CIS_IDX_STATUS_PRI
        |-> apb_rsp.prdata[0] == 1'b0 && apb_rsp.prdata[31:8] == 24'h0)
        else $error("primary spare bits not zero");
    a_mode_readback: assert property (
        rd_acc && idx == cis_pkg::CIS_IDX_MODE_CHB |-> apb_rsp.prdata == {29'h0, mode_chb_q})
        else $error("channel b mode readback wrong");
    a_irq_needs_mode: assert property (!irq_n |-> mode_any || $past(mode_any, 2))
        else $error("interrupt low in live mode");
    a_quiet_when_live: assert property (s_all_live |-> irq_n)
        else $error("interrupt low after modes live");
    a_irq_rise_write: assert property ($rose(irq_n) |-> $past(wr_acc, 2))
        else $error("interrupt rose without write");
    a_link_write: assert property (wr_acc && idx == cis_pkg::CIS_IDX_LINK_CTRL
        |=> link_enable == $past(apb_req.pwdata[0]))
        else $error("link enable not written");
    a_zero_wait: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
        else $error("ready low in access");
endmodule

bind cis_top cis_top_sva #(.NLANES(NLANES)) u_cis_top_sva (.ref_clk(ref_clk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .cond_in(cond_in), .lane_fifo_full(lane_fifo_full),
    .lane_fifo_empty(lane_fifo_empty), .link_enable(link_enable), .irq_n(irq_n));

//--- verif/cis_top_test.sv
/*
 * Self-checking bench for the interrupt status block over APB.
 * Assumes the condition source model and the bound checker.
 */
module cis_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      ref_clk;    // Bench clock, 50 ns period.
    logic                      rst;        // Reset, active high.
    cis_pkg::cis_apb_req_type  apb_req;    // Bus request.
    cis_pkg::cis_apb_rsp_type  apb_rsp;    // Bus answer.
    cis_pkg::cis_cond_type     cond_cmd;   // Requested conditions.
    cis_pkg::cis_cond_type     cond_in;    // Condition pins.
    logic [7:0]                full_cmd;   // Requested full flags.
    logic [7:0]                empty_cmd;  // Requested empty flags.
    logic [7:0]                lane_fifo_full;
    logic [7:0]                lane_fifo_empty;
    logic                      link_enable;
    logic                      irq_n;
    logic [31:0]               rdata;      // Last read data.
    logic [31:0]               b;          // Expected status bit.
    logic [11:0]               ix;         // Status register under test.
    int                        mismatches; // Failed comparisons.
    int                        n_checks;   // Comparisons made.

    cis_top u_cis_top (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .cond_in(cond_in), .lane_fifo_full(lane_fifo_full), .lane_fifo_empty(lane_fifo_empty),
        .link_enable(link_enable), .irq_n(irq_n));
    cis_cond_source u_cis_cond_source (.ref_clk(ref_clk), .rst(rst), .cond_cmd(cond_cmd),
        .full_cmd(full_cmd), .empty_cmd(empty_cmd), .cond_in(cond_in),
        .lane_fifo_full(lane_fifo_full), .lane_fifo_empty(lane_fifo_empty));

    // Compares a value seen with the value expected.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] wd);
        int n = 0;
        @(posedge ref_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i, 2'b00}, pwdata: wd};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        check("pready", {31'h0, apb_rsp.pready}, 32'h1);
        rdata = apb_rsp.prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] i, input logic [31:0] wd);
        apb(1'b1, i, wd);
    endtask

    task automatic rdchk(input string what, input logic [11:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        check(what, rdata, exp);
    endtask

    task automatic chk_irq(input logic exp);
        check("irq_n", {31'h0, irq_n}, {31'h0, exp});
    endtask

    // Sets the pins and lets them pass the synchronisers and latches.
    task automatic set_pins(input logic [8:0] c, input logic [7:0] f = 8'h0, e = 8'h0);
        @(posedge ref_clk);
        cond_cmd <= c;
        full_cmd <= f;
        empty_cmd <= e;
        repeat (8) @(posedge ref_clk);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        apb_req = '0;
        cond_cmd = '0;
        full_cmd = 8'h00;
        empty_cmd = 8'h00;
        mismatches = 0;
        n_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk("mode_chb", cis_pkg::CIS_IDX_MODE_CHB, 32'h0);
        rdchk("mode_pri", cis_pkg::CIS_IDX_MODE_PRI, 32'h0);
        rdchk("status_sec", cis_pkg::CIS_IDX_STATUS_SEC, 32'h0);
        chk_irq(1'b1);
        $display("test reset done");
        set_pins(9'h1ff);
        rdchk("live_pri", cis_pkg::CIS_IDX_STATUS_PRI, 32'hfc);
        rdchk("live_chb", cis_pkg::CIS_IDX_STATUS_CHB, 32'h07);
        chk_irq(1'b1);
        set_pins(9'h000);
        rdchk("live_pri", cis_pkg::CIS_IDX_STATUS_PRI, 32'h0);
        rdchk("live_chb", cis_pkg::CIS_IDX_STATUS_CHB, 32'h0);
        $display("test live done");
        wr(cis_pkg::CIS_IDX_STATUS_SEC, 32'hff);
        rdchk("status_sec", cis_pkg::CIS_IDX_STATUS_SEC, 32'h0);
        wr(cis_pkg::CIS_IDX_MODE_CHB, 32'hff);
        rdchk("mode_chb", cis_pkg::CIS_IDX_MODE_CHB, 32'h07);
        wr(cis_pkg::CIS_IDX_MODE_PRI, 32'hff);
        rdchk("mode_pri", cis_pkg::CIS_IDX_MODE_PRI, 32'hfe);
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped", {31'h0, apb_rsp.pslverr}, 32'h1);
        $display("test registers done");
        // Each condition in turn, in latched mode.
        for (int i = 0; i < 9; i++) begin
            ix = (i < 3) ? cis_pkg::CIS_IDX_STATUS_CHB : cis_pkg::CIS_IDX_STATUS_PRI;
            b = (i < 3) ? (32'h1 << i) : (32'h1 << (i - 1));
            set_pins(9'h001 << i);
            rdchk("latched", ix, b);
            chk_irq(1'b0);
            set_pins(9'h000);
            wr(ix, 32'h0);
            rdchk("held", ix, b);
            wr(ix, b);
            rdchk("cleared", ix, 32'h0);
            repeat (2) @(posedge ref_clk);
            chk_irq(1'b1);
            set_pins(9'h001 << i);
            wr(ix, b);
            rdchk("no_edge", ix, 32'h0);
            set_pins(9'h000);
        end
        $display("test latched done");
        wr(cis_pkg::CIS_IDX_MODE_PRI, 32'h0);
        wr(cis_pkg::CIS_IDX_LINK_CTRL, 32'h1);
        @(posedge ref_clk);
        check("link_enable", {31'h0, link_enable}, 32'h1);
        set_pins(9'h000, 8'h08);
        rdchk("lane_full", cis_pkg::CIS_IDX_LANE_FULL, 32'h08);
        rdchk("lane_err", cis_pkg::CIS_IDX_STATUS_PRI, 32'h02);
        set_pins(9'h000, 8'h00, 8'h01);
        rdchk("lane_empty", cis_pkg::CIS_IDX_LANE_EMPTY, 32'h01);
        set_pins(9'h000);
        rdchk("lane_err", cis_pkg::CIS_IDX_STATUS_PRI, 32'h02);
        wr(cis_pkg::CIS_IDX_LINK_CTRL, 32'h0);
        rdchk("lane_err", cis_pkg::CIS_IDX_STATUS_PRI, 32'h0);
        wr(cis_pkg::CIS_IDX_MODE_PRI, 32'h02);
        wr(cis_pkg::CIS_IDX_LINK_CTRL, 32'h1);
        set_pins(9'h000, 8'h80);
        rdchk("lane_latch", cis_pkg::CIS_IDX_STATUS_PRI, 32'h02);
        chk_irq(1'b0);
        wr(cis_pkg::CIS_IDX_LINK_CTRL, 32'h0);
        set_pins(9'h000);
        rdchk("lane_held", cis_pkg::CIS_IDX_STATUS_PRI, 32'h02);
        wr(cis_pkg::CIS_IDX_STATUS_PRI, 32'h02);
        rdchk("lane_clear", cis_pkg::CIS_IDX_STATUS_PRI, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk_irq(1'b1);
        $display("test lane done");
        complete_run();
    end
endmodule
